// ===== bench/host_bus_model.sv
// Host controller model issuing APB transfers to the configuration registers
`default_nettype none
module host_bus_model
    import adc_cfg_pkg::*;
(
    input  wire logic              pclk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic      [ADDR_W-1:0] paddr,
    output logic      [DATA_W-1:0] pwdata,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] rd,
                        output logic err);
        logic [DATA_W-1:0] wd;
        wd = d;
        if (a[5:2] == IDX_MAIN_CONFIG) wd[7:0] = UNUSED_ONES;
        else if (a[5:2] == IDX_I_OFFSET || a[5:2] == IDX_I_FULLSCALE) wd[6:0] = 7'h7F;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the bench watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data lines must not look valid
        pwdata  <= ~wd;
    endtask
endmodule // host_bus_model
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the output mode, offset and full-scale registers
`default_nettype none
module tb_top
    import adc_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic              extended_control_pin = 1'b1;
    logic              swing_select_pin = 1'b0;
    logic              output_edge_pin = 1'b0;
    logic              clocking_ddr, demux_enable, data_on_rising_edge;
    logic              output_swing_normal, data_clock_phase_90, offset_negative;
    logic [7:0]        offset_magnitude;
    logic [8:0]        full_scale_code;
    int                err_total = 0;
    int                cmp_count = 0;

    always #25 pclk = ~pclk;

    adc_output_offset_gain_regs u_adc_output_offset_gain_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .extended_control_pin(extended_control_pin), .swing_select_pin(swing_select_pin),
        .output_edge_pin(output_edge_pin), .clocking_ddr(clocking_ddr),
        .demux_enable(demux_enable), .data_on_rising_edge(data_on_rising_edge),
        .output_swing_normal(output_swing_normal), .data_clock_phase_90(data_clock_phase_90),
        .offset_magnitude(offset_magnitude), .offset_negative(offset_negative),
        .full_scale_code(full_scale_code));

    host_bus_model u_host_bus_model (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] r;
        logic        e;
        u_host_bus_model.xfer(1'b1, a, d, r, e);
        check(32'(e), 32'(exp_err), "write error flag");
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        u_host_bus_model.xfer(1'b0, a, 32'h0, r, e);
        check(32'(e), 32'h0, "read error flag");
        check(r & mask, exp, "read data");
    endtask

    task automatic test_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        #1;
        check(32'(offset_magnitude), 32'h0, "offset mag");
        check(32'(offset_negative), 32'h0, "offset sign");
        check(32'(full_scale_code), 32'(FS_DEFAULT), "fs default");
        check(32'(output_swing_normal), 32'h1, "swing");
        check(32'(data_on_rising_edge), 32'h0, "edge");
        check(32'(clocking_ddr), 32'h1, "ddr");
        rd(8'h20, 32'h01FF_FFFF, 32'h00AE_0000);
        rd(8'h08, 32'hFFFF_FFFF, 32'h0);
        $display("test reset done");
    endtask

    task automatic test_offset();
        wr(8'h08, 32'h0000_A5FF, 1'b0);
        #1;
        check(32'(offset_magnitude), 32'hA5, "offset mag");
        check(32'(offset_negative), 32'h1, "offset sign");
        wr(8'h08, 32'h0000_FF7F, 1'b0);
        #1;
        check(32'(offset_magnitude), 32'hFF, "offset max");
        check(32'(offset_negative), 32'h0, "offset pos");
        wr(8'h30, 32'h0000_00FF, 1'b1);
        wr(8'h09, 32'h0000_11FF, 1'b1);
        wr(8'h48, 32'h0000_22FF, 1'b1);
        #1;
        check(32'(offset_magnitude), 32'hFF, "refused write kept");
        rd(8'h20, 32'h0000_01FF, 32'h0000_00FF);
        wr(8'h20, 32'h0100_0000, 1'b0);
        rd(8'h20, 32'h0100_0000, 32'h0);
        $display("test offset done");
    endtask

    task automatic test_full_scale();
        logic [8:0] codes [5] = '{9'h000, 9'h1FF, 9'h0C0, 9'h1C0, 9'h100};
        foreach (codes[i]) begin
            wr(8'h0C, {16'h0, codes[i], 7'h7F}, 1'b0);
            #1;
            check(32'(full_scale_code), 32'(codes[i]), "fs code");
        end
        $display("test full scale done");
    endtask

    task automatic test_modes();
        logic [2:0] v;
        logic       ddr;
        logic       dmx;
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            wr(8'h04, {20'h0, v[2], v[1], 1'b1, v[0], 8'hFF}, 1'b0);
            repeat (2) @(posedge pclk);
            #1;
            ddr = ~v[1];
            dmx = ddr & ~v[0];
            check(32'(clocking_ddr), 32'(ddr), "ddr");
            check(32'(demux_enable), 32'(dmx), "demux");
            check(32'(data_on_rising_edge), 32'(~ddr & v[0]), "edge");
            check(32'(data_clock_phase_90), 32'(v[2] & dmx), "phase");
        end
        $display("test modes done");
    endtask

    task automatic test_swing();
        wr(8'h04, 32'h0000_04FF, 1'b0);
        repeat (2) @(posedge pclk);
        #1;
        check(32'(output_swing_normal), 32'h0, "swing reduced");
        check(32'(data_on_rising_edge), 32'h0, "falling edge");
        @(posedge pclk);
        extended_control_pin <= 1'b0;
        swing_select_pin <= 1'b1;
        output_edge_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        #1;
        check(32'(output_swing_normal), 32'h1, "swing from pin");
        check(32'(data_on_rising_edge), 32'h1, "edge from pin");
        @(posedge pclk);
        extended_control_pin <= 1'b1;
        $display("test swing done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        err_total++;
        report_and_stop();
    end

    initial begin
        test_reset();
        test_offset();
        test_full_scale();
        test_modes();
        test_swing();
        test_reset();
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire

// ===== rtl/adc_cfg_pkg.sv
// Register map, field positions, reset values and bus constants for the converter configuration
`default_nettype none
package adc_cfg_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned REG_W  = 16;

    // Register indexes; byte address is four times the index
    localparam logic [3:0] IDX_MAIN_CONFIG = 4'h1;
    localparam logic [3:0] IDX_I_OFFSET    = 4'h2;
    localparam logic [3:0] IDX_I_FULLSCALE = 4'h3;
    localparam logic [3:0] IDX_STATUS      = 4'h8;

    // Main configuration fields
    localparam int unsigned CFG_PHASE_BIT  = 11;
    localparam int unsigned CFG_CLKMODE_BIT = 10;
    localparam int unsigned CFG_SWING_BIT  = 9;
    localparam int unsigned CFG_EDGE_BIT   = 8;
    localparam logic [15:0] CFG_RESET      = 16'h02FF;

    // Offset and full-scale fields
    localparam int unsigned OFS_MAG_LSB    = 8;
    localparam int unsigned OFS_SIGN_BIT   = 7;
    localparam int unsigned FS_LSB         = 7;
    localparam logic [15:0] OFS_RESET      = 16'h007F;
    localparam logic [15:0] FS_RESET       = 16'h807F;
    localparam logic [8:0]  FS_DEFAULT     = 9'h100;
    localparam logic [7:0]  UNUSED_ONES    = 8'hFF;

    // Status field positions
    localparam int unsigned ST_OFS_LSB     = 0;
    localparam int unsigned ST_OFS_NEG     = 8;
    localparam int unsigned ST_FS_LSB      = 9;
    localparam int unsigned ST_DDR         = 18;
    localparam int unsigned ST_DEMUX       = 19;
    localparam int unsigned ST_RISING      = 20;
    localparam int unsigned ST_SWING       = 21;
    localparam int unsigned ST_PHASE90     = 22;
    localparam int unsigned ST_EXTCTRL     = 23;
    localparam int unsigned ST_RSVD_ERR    = 24;
endpackage
`default_nettype wire

// ===== rtl/adc_output_offset_gain_regs.sv
// APB register file for output mode, I-channel offset and I-channel full-scale adjust
// Behaviour
// (RL1) Swing bit 9 selects normal amplitude at 1 and reduced at 0, mirrors the pin, resets to 1.
// (RL2) In SDR, bit 8 makes data change on the rising clock edge at 1 and falling at 0; resets 0.
// (RL3) In DDR, bit 8 selects non-demultiplexed output at 1 and demultiplexed output at 0.
// (RL4) DDR with non-demultiplexed output keeps 0 degree clock phase; the 90 degree option is void.
// (RL5) Software writes ones into every unused low bit of the three registers.
// (RL6) Software writes the main configuration register only during power-up set-up.
// (RL7) Offset magnitude in bits 15:8 runs linearly from zero at 00h to about 45 mV at FFh.
// (RL8) Offset bit 7 is the sign: 0 positive, 1 negative, for a range of plus or minus 45 mV.
// (RL9) After reset the offset magnitude is zero until software writes the register.
// (RL10) Full-scale adjust is the 9-bit field 15:7, spanning plus or minus 20 percent.
// (RL11) Full-scale code zero is 560 mVpp, 100h is 700 mVpp and the default, 1FFh is 840 mVpp.
// (RL12) Software keeps the full-scale code between 0C0h and 1C0h for best performance.
// (RL13) A new full-scale value takes effect at once, with no recalibration.
// (RL14) Clocking-mode bit selects DDR output at 0 and SDR output at 1.
//
// The implementer's own choice: register access over APB.
`default_nettype none
module adc_output_offset_gain_regs
    import adc_cfg_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              extended_control_pin,
    input  wire logic              swing_select_pin,
    input  wire logic              output_edge_pin,
    output logic                   clocking_ddr,
    output logic                   demux_enable,
    output logic                   data_on_rising_edge,
    output logic                   output_swing_normal,
    output logic                   data_clock_phase_90,
    output logic      [7:0]        offset_magnitude,
    output logic                   offset_negative,
    output logic      [8:0]        full_scale_code
);
    output_mode_if mode_bus ();

    logic [REG_W-1:0]  cfg_r;
    logic [REG_W-1:0]  ofs_r;
    logic [REG_W-1:0]  fs_r;
    logic [7:0]        offset_magnitude_r;
    logic              offset_negative_r;
    logic [8:0]        full_scale_code_r;
    logic              rsvd_err_r;
    logic [DATA_W-1:0] prdata_r;
    logic              pslverr_r;
    logic [2:0]        pin_meta_r;
    logic [2:0]        pin_sync_r;
    logic [3:0]        index;
    logic              word_ok;
    logic              setup;
    logic              access;
    logic              wr_en;
    logic              wr_cfg;
    logic              wr_ofs;
    logic              wr_fs;
    logic              wr_status;
    logic              rsvd_bad;
    logic              hit_wo;
    logic              hit_status;
    logic [DATA_W-1:0] status_word;
    logic              wrote_ofs_r;
    logic              wrote_fs_r;

    assign index      = paddr[5:2];
    assign word_ok    = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:6] == '0);
    assign setup      = psel && !penable;
    assign access     = psel && penable;
    assign hit_wo     = word_ok && (index == IDX_MAIN_CONFIG || index == IDX_I_OFFSET
                                    || index == IDX_I_FULLSCALE);
    assign hit_status = word_ok && (index == IDX_STATUS);

    // Zero wait states; error is decided in the setup cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r && access;

    assign wr_en     = access && pwrite && !pslverr_r;
    assign wr_cfg    = wr_en && (index == IDX_MAIN_CONFIG);
    assign wr_ofs    = wr_en && (index == IDX_I_OFFSET);
    assign wr_fs     = wr_en && (index == IDX_I_FULLSCALE);
    assign wr_status = wr_en && (index == IDX_STATUS);

    // Two-stage synchronisers for the mode pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
        end else begin
            pin_meta_r <= {extended_control_pin, swing_select_pin, output_edge_pin};
            pin_sync_r <= pin_meta_r;
        end
    end

    // Setup cycle: decode, pick read data and error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r  <= '0;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= !(hit_wo || hit_status);
            // Write-only registers read as zero
            prdata_r  <= (!pwrite && hit_status) ? status_word : '0;
        end
    end

    // (RL6) Written any time; software limits it to start-up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= pwdata[REG_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ofs_r <= OFS_RESET;
        end else if (wr_ofs) begin
            ofs_r <= pwdata[REG_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_r <= FS_RESET;
        end else if (wr_fs) begin
            fs_r <= pwdata[REG_W-1:0];
        end
    end

    // (RL7) offset magnitude to the trim
    // (RL9) zero until written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_magnitude_r <= 8'h00;
        end else if (wr_ofs) begin
            offset_magnitude_r <= pwdata[OFS_MAG_LSB +: 8];
        end
    end

    // (RL8) offset sign
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_negative_r <= 1'b0;
        end else if (wr_ofs) begin
            offset_negative_r <= pwdata[OFS_SIGN_BIT];
        end
    end

    // (RL11) resets to the 700 mVpp code
    // (RL10) nine-bit gain field
    // (RL13) applied next cycle, no recalibration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full_scale_code_r <= FS_DEFAULT;
        end else if (wr_fs) begin
            full_scale_code_r <= pwdata[FS_LSB +: 9];
        end
    end

    // (RL5) flag writes that leave unused bits low
    always_comb begin
        rsvd_bad = 1'b0;
        if (wr_cfg) begin
            rsvd_bad = pwdata[7:0] != UNUSED_ONES;
        end else if (wr_ofs || wr_fs) begin
            rsvd_bad = pwdata[6:0] != UNUSED_ONES[6:0];
        end
    end

    // Sticky; a new violation beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rsvd_err_r <= 1'b0;
        end else if (rsvd_bad) begin
            rsvd_err_r <= 1'b1;
        end else if (wr_status && pwdata[ST_RSVD_ERR]) begin
            rsvd_err_r <= 1'b0;
        end
    end

    // (RL14) clocking mode bit to decoder
    assign mode_bus.clocking_mode_select = cfg_r[CFG_CLKMODE_BIT];
    assign mode_bus.ddr_phase_select     = cfg_r[CFG_PHASE_BIT];
    assign mode_bus.output_swing_select  = cfg_r[CFG_SWING_BIT];
    assign mode_bus.edge_or_demux_select = cfg_r[CFG_EDGE_BIT];
    assign mode_bus.extended_control     = pin_sync_r[2];
    assign mode_bus.swing_select_pin     = pin_sync_r[1];
    assign mode_bus.output_edge_pin      = pin_sync_r[0];

    output_mode_decode u_decode (
        .pclk    (pclk),
        .presetn (presetn),
        .mode    (mode_bus)
    );

    assign clocking_ddr        = mode_bus.ddr_mode;
    assign demux_enable        = mode_bus.demux_enable;
    assign data_on_rising_edge = mode_bus.data_on_rising_edge;
    assign output_swing_normal = mode_bus.swing_normal;
    assign data_clock_phase_90 = mode_bus.phase_90;
    assign offset_magnitude    = offset_magnitude_r;
    assign offset_negative     = offset_negative_r;
    assign full_scale_code     = full_scale_code_r;

    always_comb begin
        status_word                         = '0;
        status_word[ST_OFS_LSB +: 8]        = offset_magnitude_r;
        status_word[ST_OFS_NEG]             = offset_negative_r;
        status_word[ST_FS_LSB +: 9]         = full_scale_code_r;
        status_word[ST_DDR]                 = mode_bus.ddr_mode;
        status_word[ST_DEMUX]               = mode_bus.demux_enable;
        status_word[ST_RISING]              = mode_bus.data_on_rising_edge;
        status_word[ST_SWING]               = mode_bus.swing_normal;
        status_word[ST_PHASE90]             = mode_bus.phase_90;
        status_word[ST_EXTCTRL]             = pin_sync_r[2];
        status_word[ST_RSVD_ERR]            = rsvd_err_r;
    end

    // Helper: have the offset and full-scale registers each been written since reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wrote_ofs_r <= 1'b0;
            wrote_fs_r  <= 1'b0;
        end else begin
            wrote_ofs_r <= wrote_ofs_r || wr_ofs;
            wrote_fs_r  <= wrote_fs_r || wr_fs;
        end
    end

    property p_offset_zero_until_written;
        @(posedge pclk) disable iff (!presetn)
        !wrote_ofs_r |-> (offset_magnitude == 8'h00) && !offset_negative;
    endproperty
    a_offset_zero_until_written: assert property (p_offset_zero_until_written) // RL9
        else $error("offset not zero before first write");

    property p_offset_write;
        @(posedge pclk) disable iff (!presetn)
        wr_ofs |=> offset_magnitude == $past(pwdata[15:8]);
    endproperty
    a_offset_write: assert property (p_offset_write) // RL7
        else $error("offset magnitude not taken from bits 15:8");

    property p_offset_sign;
        @(posedge pclk) disable iff (!presetn)
        wr_ofs |=> offset_negative == $past(pwdata[7]);
    endproperty
    a_offset_sign: assert property (p_offset_sign) // RL8
        else $error("offset sign not taken from bit 7");

    property p_fs_default;
        @(posedge pclk) disable iff (!presetn)
        !wrote_fs_r |-> full_scale_code == FS_DEFAULT;
    endproperty
    a_fs_default: assert property (p_fs_default) // RL11
        else $error("full-scale default is not 100h");

    property p_fs_immediate;
        @(posedge pclk) disable iff (!presetn)
        (wr_fs && pready) ##1 !wr_fs[*2] |-> full_scale_code == $past(pwdata[FS_LSB +: 9], 2);
    endproperty
    a_fs_immediate: assert property (p_fs_immediate) // RL13
        else $error("full-scale value not applied or not held");

    property p_fs_field;
        @(posedge pclk) disable iff (!presetn)
        wr_fs |=> full_scale_code == $past(pwdata[15:7]);
    endproperty
    a_fs_field: assert property (p_fs_field) // RL10
        else $error("full-scale code not taken from bits 15:7");

    property p_swing_ext;
        @(posedge pclk) disable iff (!presetn)
        (wr_cfg && pin_sync_r[2]) ##1 (pin_sync_r[2] && !wr_cfg)
            |=> output_swing_normal == $past(pwdata[9], 2);
    endproperty
    a_swing_ext: assert property (p_swing_ext) // RL1
        else $error("swing output does not follow bit 9");

    property p_sdr_edge;
        @(posedge pclk) disable iff (!presetn)
        (wr_cfg && pwdata[10] && pin_sync_r[2]) ##1 (pin_sync_r[2] && !wr_cfg)
            |=> data_on_rising_edge == $past(pwdata[8], 2);
    endproperty
    a_sdr_edge: assert property (p_sdr_edge) // RL2
        else $error("SDR edge select wrong");

    property p_clock_mode;
        @(posedge pclk) disable iff (!presetn)
        wr_cfg ##1 !wr_cfg |=> clocking_ddr == !$past(pwdata[10], 2);
    endproperty
    a_clock_mode: assert property (p_clock_mode) // RL14
        else $error("clocking mode does not follow bit 10");

    property p_unmapped_error;
        @(posedge pclk) disable iff (!presetn)
        (setup && !(hit_wo || hit_status)) ##1 access |-> pslverr && pready;
    endproperty
    a_unmapped_error: assert property (p_unmapped_error)
        else $error("unmapped access not refused");

    property p_refused_write;
        @(posedge pclk) disable iff (!presetn)
        (pslverr && pwrite) |=> $stable(cfg_r) && $stable(ofs_r) && $stable(fs_r);
    endproperty
    a_refused_write: assert property (p_refused_write)
        else $error("refused write changed a register");

    property p_offset_hold;
        @(posedge pclk) disable iff (!presetn)
        (presetn && !wr_ofs) |=> $stable(offset_magnitude) && $stable(offset_negative);
    endproperty
    a_offset_hold: assert property (p_offset_hold) // RL7
        else $error("offset changed without a write");

    property p_fs_hold;
        @(posedge pclk) disable iff (!presetn)
        (presetn && !wr_fs) |=> $stable(full_scale_code);
    endproperty
    a_fs_hold: assert property (p_fs_hold) // RL13
        else $error("full-scale code changed without a write");

    // Sampled reset in the antecedent skips the release edge
    property p_swing_pin;
        @(posedge pclk) disable iff (!presetn)
        (presetn && !pin_sync_r[2]) |=> output_swing_normal == $past(pin_sync_r[1]);
    endproperty
    a_swing_pin: assert property (p_swing_pin) // RL1
        else $error("swing output does not follow its pin");

    property p_edge_pin;
        @(posedge pclk) disable iff (!presetn)
        (presetn && !pin_sync_r[2])
            |=> data_on_rising_edge == ($past(cfg_r[CFG_CLKMODE_BIT]) && $past(pin_sync_r[0]));
    endproperty
    a_edge_pin: assert property (p_edge_pin) // RL2
        else $error("SDR edge does not follow its pin");

    property p_ddr_demux;
        @(posedge pclk) disable iff (!presetn)
        (presetn && !cfg_r[CFG_CLKMODE_BIT]) |=> demux_enable == !$past(cfg_r[CFG_EDGE_BIT]);
    endproperty
    a_ddr_demux: assert property (p_ddr_demux) // RL3
        else $error("DDR demux does not follow bit 8");
endmodule // adc_output_offset_gain_regs
`default_nettype wire

// ===== rtl/output_mode_decode.sv
// Decodes clocking, edge, demux, phase and swing controls from configuration and pins
`default_nettype none
module output_mode_decode
    import adc_cfg_pkg::*;
(
    input  wire logic    pclk,
    input  wire logic    presetn,
    output_mode_if.dec   mode
);
    logic sdr_mode;

    assign sdr_mode = mode.clocking_mode_select;

    // (RL14) clocking mode select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode.ddr_mode <= 1'b1;
        end else begin
            mode.ddr_mode <= !sdr_mode;
        end
    end

    // (RL3) demux only in DDR
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode.demux_enable <= 1'b1;
        end else begin
            mode.demux_enable <= !sdr_mode && !mode.edge_or_demux_select;
        end
    end

    // (RL2) SDR edge choice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode.data_on_rising_edge <= 1'b0;
        end else if (mode.extended_control) begin
            mode.data_on_rising_edge <= sdr_mode && mode.edge_or_demux_select;
        end else begin
            mode.data_on_rising_edge <= sdr_mode && mode.output_edge_pin;
        end
    end

    // (RL1) swing from register or pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode.swing_normal <= 1'b1;
        end else if (mode.extended_control) begin
            mode.swing_normal <= mode.output_swing_select;
        end else begin
            mode.swing_normal <= mode.swing_select_pin;
        end
    end

    // (RL4) no 90 degree phase unless demuxed DDR
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode.phase_90 <= 1'b0;
        end else begin
            mode.phase_90 <= mode.ddr_phase_select && !sdr_mode && !mode.edge_or_demux_select;
        end
    end

    property p_phase_needs_demux;
        @(posedge pclk) disable iff (!presetn)
        mode.phase_90 |-> (mode.ddr_mode && mode.demux_enable);
    endproperty
    a_phase_needs_demux: assert property (p_phase_needs_demux) // RL4
        else $error("90 degree phase outside demuxed DDR");

    property p_sdr_no_demux;
        @(posedge pclk) disable iff (!presetn)
        sdr_mode ##1 sdr_mode |-> !mode.demux_enable && !mode.ddr_mode;
    endproperty
    a_sdr_no_demux: assert property (p_sdr_no_demux) // RL3
        else $error("demux or DDR active in SDR mode");
endmodule // output_mode_decode
`default_nettype wire

// ===== rtl/output_mode_if.sv
// Configuration bits and decoded output-mode controls between register file and decoder
`default_nettype none
interface output_mode_if;
    logic ddr_phase_select;
    logic clocking_mode_select;
    logic output_swing_select;
    logic edge_or_demux_select;
    logic extended_control;
    logic swing_select_pin;
    logic output_edge_pin;
    logic ddr_mode;
    logic demux_enable;
    logic data_on_rising_edge;
    logic swing_normal;
    logic phase_90;

    modport regs (output ddr_phase_select, clocking_mode_select, output_swing_select,
                  edge_or_demux_select, extended_control, swing_select_pin, output_edge_pin,
                  input ddr_mode, demux_enable, data_on_rising_edge, swing_normal, phase_90);
    modport dec  (input ddr_phase_select, clocking_mode_select, output_swing_select,
                  edge_or_demux_select, extended_control, swing_select_pin, output_edge_pin,
                  output ddr_mode, demux_enable, data_on_rising_edge, swing_normal, phase_90);
endinterface
`default_nettype wire
